// ===== drc_cfg.svh
// constants for the run-control register group: offsets, fields, resets
// assumes a 16-bit register port addressed by the printed word offsets
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define DRC_OFS_SLEEP        16'hf400
`define DRC_OFS_LAUNCH       16'hf402
`define DRC_OFS_HALT         16'hf403
`define DRC_OFS_ENTRY        16'hf404
`define DRC_OFS_STATE        16'hf405
`define DRC_OFS_FAULT_CLEAR  16'hf421
`define DRC_OFS_FAULT_FLAG   16'hf427

// ****************************************
// fields and reset values
// ****************************************
`define DRC_CTRL_BIT         0
`define DRC_STATE_MSB        2
`define DRC_RST_HALT         16'h0000
`define DRC_RST_ENTRY        16'h0000
`define DRC_RST_STATE        16'h0000
`define DRC_RST_FAULT_CLEAR  16'h0000
`define DRC_RST_SLEEP        16'h0000
`define DRC_RST_LAUNCH       16'h0000

`endif

// ===== drc_edge.sv
// rising and falling edge detector for a register bit on core_clk
// assumes the input is already synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module drc_edge
  import drc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_reg;
  logic prev_next;

  always_comb
  begin
    prev_next = level;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      prev_reg <= 1'b0;
    else
      prev_reg <= prev_next;
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule
`default_nettype wire

// ===== drc_host.sv
// host model driving the register port
// assumes core_clk from the bench; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module drc_host
(
  input  wire logic        core_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic cyc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge core_clk);
    {reg_wr, reg_rd} = 2'b00;
    // released bus shows no stale value
    reg_wdata = ~d;
  endtask
  task automatic clear_fault();
    cyc(1'b1, 16'hf421, 16'h0001);
    cyc(1'b1, 16'hf421, 16'h0000);
  endtask
  // halt is only used ahead of a relaunch here
endmodule
`default_nettype wire

// ===== drc_pkg.sv
// types for the run-control register group
// assumes drc_cfg.svh supplies the numeric constants
package drc_pkg;
  // core state codes as read back by the host
  typedef enum logic [2:0] {
    DRC_STOPPED = 3'h0,
    DRC_RUNNING = 3'h1,
    DRC_PAUSED  = 3'h2,
    DRC_SLEEP   = 3'h3,
    DRC_STALLED = 3'h4
  } drc_state_e;

  typedef logic [15:0] drc_word_t;
endpackage

// ===== drc_run_control.sv
// run-control register group of the audio dsp core
// assumes a synchronous 16-bit host register port on core_clk and a
// sequencer that reports pause, sleep, stall and frame-end as levels/pulses
`timescale 1ns/1ps
`default_nettype none
`include "drc_cfg.svh"

// How it works
// - rising edge of halt bit stops the core at once, any state
// - while halt bit is one, core stays stopped and launches are ignored
// - falling edge of halt bit does not restart; it permits later launch
// - launch loads program counter from 16-bit entry register, reset zero
// - 3-bit state field shows live core state when read
// - state 000 when not running: after boot and after halt
// - state 001 while executing normally
// - state 010 when paused by pause instruction, clock gated
// - state 011 when sleeping by sleep instruction awaiting sample
// - state 100 when stalled servicing simultaneous requests
// - state register not writable; only sleep, launch, halt and sequencer pause/stall/sleep change it
// - rising edge of fault-clear clears flag and resets fault manager; here a fault_event in the same cycle leaves the flag set
// - launch bit rising edge starts core; falling edge does nothing
// - sleep request takes effect only after current sample or block
module drc_run_control
  import drc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        seq_pause,
  input  wire logic        seq_sleep,
  input  wire logic        seq_stall,
  input  wire logic        seq_frame_end,
  input  wire logic        fault_event,
  output logic             fault_flag,
  output logic             fault_mgr_reset,
  output logic             core_run_en,
  output logic             core_clk_gate_en,
  output logic             pc_load,
  output logic      [15:0] pc_load_value,
  output logic             irq_mask_all
);

  // ****************************************
  // register file
  // ****************************************
  drc_word_t  sleep_reg, sleep_next;
  drc_word_t  launch_reg, launch_next;
  drc_word_t  halt_reg, halt_next;
  drc_word_t  entry_reg, entry_next;
  drc_word_t  fclr_reg, fclr_next;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = reg_wr && (a == ofs);
  endfunction

  always_comb
  begin
    sleep_next  = sleep_reg;
    launch_next = launch_reg;
    halt_next   = halt_reg;
    entry_next  = entry_reg;
    fclr_next   = fclr_reg;
    if (hit(reg_addr, `DRC_OFS_SLEEP))
      sleep_next = reg_wdata;
    if (hit(reg_addr, `DRC_OFS_LAUNCH))
      launch_next = reg_wdata;
    if (hit(reg_addr, `DRC_OFS_HALT))
      halt_next = reg_wdata;
    if (hit(reg_addr, `DRC_OFS_ENTRY))
      entry_next = reg_wdata;
    if (hit(reg_addr, `DRC_OFS_FAULT_CLEAR))
      fclr_next = reg_wdata;
    // writes to the state offset are dropped on purpose
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sleep_reg  <= `DRC_RST_SLEEP;
      launch_reg <= `DRC_RST_LAUNCH;
      halt_reg   <= `DRC_RST_HALT;
      entry_reg  <= `DRC_RST_ENTRY;
      fclr_reg   <= `DRC_RST_FAULT_CLEAR;
    end
    else
    begin
      sleep_reg  <= sleep_next;
      launch_reg <= launch_next;
      halt_reg   <= halt_next;
      entry_reg  <= entry_next;
      fclr_reg   <= fclr_next;
    end
  end

  // ****************************************
  // control edges
  // ****************************************
  logic launch_rise;
  logic halt_rise;
  logic fclr_rise;

  drc_edge u_launch_edge (
    .core_clk (core_clk),
    .resetn   (resetn),
    .level    (launch_reg[`DRC_CTRL_BIT]),
    .rise     (launch_rise),
    .fall     ()
  );

  drc_edge u_halt_edge (
    .core_clk (core_clk),
    .resetn   (resetn),
    .level    (halt_reg[`DRC_CTRL_BIT]),
    .rise     (halt_rise),
    .fall     ()
  );

  drc_edge u_fclr_edge (
    .core_clk (core_clk),
    .resetn   (resetn),
    .level    (fclr_reg[`DRC_CTRL_BIT]),
    .rise     (fclr_rise),
    .fall     ()
  );

  logic halt_level;
  logic sleep_level;
  assign halt_level  = halt_reg[`DRC_CTRL_BIT];
  assign sleep_level = sleep_reg[`DRC_CTRL_BIT];

  // ****************************************
  // core state machine
  // ****************************************
  // binary, not gray, along stopped->running->paused; sleep/stall are side branches
  drc_state_e state_reg, state_next;
  logic       pc_load_next;
  logic       hib_sleep_reg, hib_sleep_next;

  always_comb
  begin
    state_next     = state_reg;
    pc_load_next   = 1'b0;
    hib_sleep_next = hib_sleep_reg;
    if (!sleep_level)
      hib_sleep_next = 1'b0;
    if (halt_rise || halt_level)
    begin
      // halt overrides everything, even an undefined state
      state_next     = DRC_STOPPED;
      hib_sleep_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        DRC_STOPPED:
        begin
          if (launch_rise)
          begin
            state_next   = DRC_RUNNING;
            pc_load_next = 1'b1;
          end
        end
        DRC_RUNNING:
        begin
          if (seq_pause)
            state_next = DRC_PAUSED;
          else if (seq_stall)
            state_next = DRC_STALLED;
          else if (seq_frame_end && sleep_level)
          begin
            // controlled sleep waits for the block in flight
            state_next     = DRC_SLEEP;
            hib_sleep_next = 1'b1;
          end
          else if (seq_sleep)
            state_next = DRC_SLEEP;
        end
        DRC_PAUSED:
        begin
          if (!seq_pause)
            state_next = DRC_RUNNING;
        end
        DRC_SLEEP:
        begin
          if (!hib_sleep_reg && !seq_sleep)
            state_next = DRC_RUNNING;
          else if (hib_sleep_reg && !sleep_level)
            state_next = DRC_RUNNING;
        end
        DRC_STALLED:
        begin
          if (!seq_stall)
            state_next = DRC_RUNNING;
        end
        default:
        begin
          state_next = DRC_STOPPED;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg     <= DRC_STOPPED;
      pc_load       <= 1'b0;
      hib_sleep_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      pc_load       <= pc_load_next;
      hib_sleep_reg <= hib_sleep_next;
    end
  end

  assign pc_load_value    = entry_reg;
  assign core_run_en      = (state_reg == DRC_RUNNING);
  assign core_clk_gate_en = (state_reg != DRC_PAUSED) && (state_reg != DRC_STOPPED);
  assign irq_mask_all     = sleep_level;

  // ****************************************
  // fault manager clear
  // ****************************************
  logic fault_flag_next;
  logic fmr_next;

  always_comb
  begin
    fault_flag_next = fault_flag;
    fmr_next        = fclr_rise;
    if (fclr_rise)
      fault_flag_next = 1'b0;
    if (fault_event)
      fault_flag_next = 1'b1; // a new fault wins over the clear
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      fault_flag      <= 1'b0;
      fault_mgr_reset <= 1'b0;
    end
    else
    begin
      fault_flag      <= fault_flag_next;
      fault_mgr_reset <= fmr_next;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  drc_word_t rdata_next;

  always_comb
  begin
    rdata_next = reg_rdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `DRC_OFS_SLEEP:       rdata_next = sleep_reg;
        `DRC_OFS_LAUNCH:      rdata_next = launch_reg;
        `DRC_OFS_HALT:        rdata_next = halt_reg;
        `DRC_OFS_ENTRY:       rdata_next = entry_reg;
        `DRC_OFS_STATE:       rdata_next = {13'h0000, state_next};
        `DRC_OFS_FAULT_CLEAR: rdata_next = fclr_reg;
        `DRC_OFS_FAULT_FLAG:  rdata_next = {15'h0000, fault_flag};
        default:              rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      reg_rdata <= `DRC_RST_STATE;
    else
      reg_rdata <= rdata_next;
  end

endmodule
`default_nettype wire

// ===== drc_run_control_asserts.sv
// checker for the run-control register group
// assumes binding to drc_run_control; shadows host-written control bits
`timescale 1ns/1ps
`default_nettype none
module drc_ra
  import drc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        seq_pause,
  input wire logic        fault_event,
  input wire logic        fault_flag,
  input wire logic        fault_mgr_reset,
  input wire logic        core_run_en,
  input wire logic        core_clk_gate_en,
  input wire logic        pc_load,
  input wire logic [15:0] pc_load_value,
  input wire logic        irq_mask_all
);
  // ****
  // shadows
  // ****
  logic        halt_q, launch_q, clr_q, sleep_q;
  logic [15:0] entry_q;
  always_ff @(posedge core_clk)
    if (!resetn)
      {halt_q, launch_q, clr_q, sleep_q, entry_q} <= '0;
    else if (reg_wr)
      case (reg_addr)
        16'hf400: sleep_q <= reg_wdata[0];
        16'hf402: launch_q <= reg_wdata[0];
        16'hf403: halt_q <= reg_wdata[0];
        16'hf404: entry_q <= reg_wdata;
        16'hf421: clr_q <= reg_wdata[0];
        default: ;
      endcase
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_halt;
    reg_wr && reg_addr == 16'hf403 && reg_wdata[0] && !halt_q;
  endsequence
  sequence s_launch;
    reg_wr && reg_addr == 16'hf402 && reg_wdata[0] && !launch_q && !halt_q
      && !core_clk_gate_en && !seq_pause;
  endsequence
  sequence s_clr;
    reg_wr && reg_addr == 16'hf421 && reg_wdata[0] && !clr_q && !fault_event;
  endsequence
  a_halt_stops: assert property (s_halt |-> ##[1:2] !core_run_en ##1 !core_run_en)
    else $error("core still running after halt");
  a_halt_holds: assert property (halt_q && $past(halt_q, 2) |-> !core_run_en && !pc_load)
    else $error("core active while halt held");
  a_launch_load: assert property (s_launch |-> ##[1:2]
    (pc_load && pc_load_value == entry_q) ##1 (!pc_load && core_run_en))
    else $error("launch did not load entry and run");
  a_fall_noload: assert property (reg_wr && reg_addr == 16'hf402 && !reg_wdata[0]
    |=> !pc_load [*3]) else $error("launch fall loaded pc");
  a_fault_clear: assert property (s_clr |-> ##[1:2] (fault_mgr_reset && !fault_flag)
    ##1 !fault_mgr_reset) else $error("fault clear failed");
  a_fault_sets: assert property (fault_event |=> fault_flag)
    else $error("fault flag not set");
  a_mask_level: assert property (irq_mask_all == sleep_q)
    else $error("irq mask differs from sleep bit");
  a_state_width: assert property (reg_rd && reg_addr == 16'hf405
    |=> reg_rdata[15:3] == '0) else $error("state read has upper bits");
  a_run_gated: assert property (core_run_en |-> core_clk_gate_en)
    else $error("running with clock gated");
endmodule
bind drc_run_control drc_ra u_ra (.core_clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .seq_pause, .fault_event, .fault_flag, .fault_mgr_reset,
  .core_run_en, .core_clk_gate_en, .pc_load, .pc_load_value, .irq_mask_all);
`default_nettype wire

// ===== dsp_core_run_control_tb.sv
// self-checking bench for the run-control register group
// assumes drc_host as register master; sequencer levels driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t read value wrong", $time); end end
module dsp_core_run_control_tb;
  import drc_pkg::*;
  logic core_clk = 0, resetn = 0, seq_pause = 0, seq_sleep = 0, seq_stall = 0;
  logic seq_frame_end = 0, fault_event = 0, rd_q = 0;
  logic reg_wr, reg_rd, fault_flag, fault_mgr_reset, core_run_en;
  logic core_clk_gate_en, pc_load, irq_mask_all;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, pc_load_value, e;
  logic [15:0] rng = 16'h3a87;
  logic [15:0] q[$];
  logic [15:0] ofs [7] = '{16'hf400, 16'hf402, 16'hf403, 16'hf404,
                           16'hf405, 16'hf421, 16'hf427};
  logic [15:0] code [3] = '{16'h0002, 16'h0004, 16'h0003};
  int compares = 0, miscompares = 0, cnt = 0;
  drc_host u_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  drc_run_control dut (.core_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .seq_pause, .seq_sleep, .seq_stall, .seq_frame_end, .fault_event,
    .fault_flag, .fault_mgr_reset, .core_run_en, .core_clk_gate_en, .pc_load,
    .pc_load_value, .irq_mask_all);
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [15:0] xs();
    rng ^= rng << 7;
    rng ^= rng >> 9;
    rng ^= rng << 8;
    return rng;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_host.cyc(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    q.push_back(x);
    u_host.cyc(1'b0, a, 16'h0000);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic results();
    $display("counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // monitor and timeout
  // ****
  always @(posedge core_clk) rd_q <= reg_rd;
  always @(negedge core_clk)
  begin
    cnt++;
    // frame end every eighth cycle keeps controlled sleep waits short
    seq_frame_end <= (cnt % 8 == 0);
    if (rd_q === 1'b1 && q.size() > 0)
      `CHK(reg_rdata, q.pop_front())
    if (cnt > 3000)
    begin
      $display("MISMATCH %0t timeout", $time);
      miscompares++;
      results();
    end
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    idle(8);
    resetn = 1'b1;
    foreach (ofs[i]) rd(ofs[i], 16'h0000);
    wr(16'hf410, xs());
    rd(16'hf410, 16'h0000);
    wr(16'hf405, 16'hffff);
    rd(16'hf405, 16'h0000);
    $display("test reset done");
    e = xs();
    wr(16'hf404, e);
    rd(16'hf404, e);
    wr(16'hf402, 16'h0001);
    idle(3);
    rd(16'hf405, 16'h0001);
    wr(16'hf402, 16'h0000);
    idle(3);
    rd(16'hf405, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      {seq_pause, seq_stall, seq_sleep} = 3'b100 >> i;
      idle(3);
      rd(16'hf405, code[i]);
      {seq_pause, seq_stall, seq_sleep} = 3'b000;
      idle(3);
    end
    $display("test states done");
    // start just after a frame end so the next one is still seven cycles off
    while (!seq_frame_end)
      idle(1);
    wr(16'hf400, 16'h0001);
    rd(16'hf405, 16'h0001);
    idle(12);
    rd(16'hf405, 16'h0003);
    wr(16'hf400, 16'h0000);
    wr(16'hf403, 16'h0001);
    rd(16'hf405, 16'h0000);
    wr(16'hf402, 16'h0001);
    idle(3);
    rd(16'hf405, 16'h0000);
    wr(16'hf403, 16'h0000);
    idle(3);
    rd(16'hf405, 16'h0000);
    wr(16'hf402, 16'h0000);
    wr(16'hf402, 16'h0001);
    idle(3);
    rd(16'hf405, 16'h0001);
    $display("test halt done");
    fault_event = 1'b1;
    idle(1);
    fault_event = 1'b0;
    rd(16'hf427, 16'h0001);
    u_host.clear_fault();
    idle(2);
    rd(16'hf427, 16'h0000);
    idle(3);
    $display("test fault done");
    results();
  end
endmodule
`default_nettype wire
